// >>> pkg/gmq_defs.svh
/*
 * Constants for the port C pin multiplexer and input qualifier: register
 * offsets, field widths, selector codes and reset values.
 * Assumes it is included by bare name from every module file of the block; the package file does not include it.
 */
`ifndef GMQ_DEFS_SVH
`define GMQ_DEFS_SVH

`define GMQ_NPIN       24
`define GMQ_NLOW       16
`define GMQ_NDATA      16
`define GMQ_NADDR      8
`define GMQ_GRP        8
`define GMQ_NGRP       3
`define GMQ_SEL_W      2
`define GMQ_PRD_W      8
`define GMQ_AW         8
`define GMQ_DW         32
`define GMQ_WIN_SHORT  3
`define GMQ_WIN_LONG   6

`define GMQ_OFS_MUX_LO  8'h00
`define GMQ_OFS_MUX_HI  8'h04
`define GMQ_OFS_QSEL_LO 8'h08
`define GMQ_OFS_QSEL_HI 8'h0c
`define GMQ_OFS_CTRL    8'h10
`define GMQ_OFS_DIR     8'h14
`define GMQ_OFS_DOUT    8'h18
`define GMQ_OFS_DIN     8'h1c

`define GMQ_SEL_GPIO   2'h0
`define GMQ_SEL_PER1   2'h1
`define GMQ_SEL_ASYNC  2'h3
`define GMQ_SEL_BUS    1
`define GMQ_RST_WORD   32'h0000_0000
`define GMQ_RST_HALF   16'h0000
`define GMQ_RST_PINS   24'h00_0000
`define GMQ_RST_PRD    8'h00
`define GMQ_PRD_ONE    8'h01

`endif

// >>> pkg/gmq_pkg.sv
/*
 * Types shared by the pin multiplexer and qualifier modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gmq_pkg;

	typedef enum logic [1:0] {
		GMQ_SYNC,
		GMQ_WIN3,
		GMQ_WIN6,
		GMQ_ASYNC
	} gmq_qmode_t;

	typedef logic [31:0] gmq_word_t;

endpackage

// >>> src/gmq_sync.sv
/*
 * Three-stage pin synchroniser; the output moves only when the second and
 * third stages agree.
 * Assumes the pin is asynchronous to clock.
 */
`timescale 1ns/100ps
`include "gmq_defs.svh"

module gmq_sync
	import gmq_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// Pin side
	input  wire logic pin_raw,
	output logic      pin_sync
);

	logic [2:0] stage_r;
	logic [2:0] stage_nxt;
	logic       level_r;
	logic       level_nxt;

	always_comb begin
		stage_nxt = {stage_r[1:0], pin_raw};
		level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stage_r <= 3'h0;
			level_r <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			level_r <= level_nxt;
		end
	end

	assign pin_sync = level_r;

	a_sync_settle: assert property (@(posedge clock) disable iff (!rst_b)
		(stage_r[1] == stage_r[2]) |=> (level_r == $past(stage_r[2])))
		else $error("synchronised level did not follow agreeing stages");

endmodule // gmq_sync

// >>> src/gmq_qual.sv
/*
 * Per-pin input qualifier: synchronise only, three- or six-sample window,
 * or raw pass-through.
 * Assumes sample_tick comes from the pin's group counter: a one-cycle pulse, or high every cycle for a period of 0 or 1.
 */
`timescale 1ns/100ps
`include "gmq_defs.svh"

module gmq_qual
	import gmq_pkg::*;
#(
	parameter int WIN_SHORT = `GMQ_WIN_SHORT,
	parameter int WIN_LONG  = `GMQ_WIN_LONG
)(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// Control
	input  wire gmq_qmode_t mode,
	input  wire logic       sample_tick,
	// Input levels
	input  wire logic       pin_sync,
	input  wire logic       pin_raw,
	// Qualified level
	output logic            pin_qual
);

	logic [WIN_LONG-1:0] samp_r;
	logic [WIN_LONG-1:0] samp_nxt;
	logic                q_r;
	logic                q_nxt;
	logic                ones3;
	logic                zeros3;
	logic                ones6;
	logic                zeros6;
	logic                win_equal;

	always_comb begin
		samp_nxt = sample_tick ? {samp_r[WIN_LONG-2:0], pin_sync} : samp_r;
		ones3    = &samp_r[WIN_SHORT-1:0];
		zeros3   = ~|samp_r[WIN_SHORT-1:0];
		ones6    = &samp_r;
		zeros6   = ~|samp_r;
		win_equal = 1'b0;
		q_nxt    = q_r;
		unique case (mode)
			GMQ_SYNC: begin
				q_nxt = pin_sync;
			end
			GMQ_WIN3: begin
				win_equal = ones3 | zeros3;
				q_nxt     = win_equal ? ones3 : q_r;
			end
			GMQ_WIN6: begin
				win_equal = ones6 | zeros6;
				q_nxt     = win_equal ? ones6 : q_r;
			end
			GMQ_ASYNC: begin
				q_nxt = pin_sync;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			samp_r <= '0;
			q_r    <= 1'b0;
		end else begin
			samp_r <= samp_nxt;
			q_r    <= q_nxt;
		end
	end

	// The raw path skips every flip-flop here; the consumer must synchronise.
	assign pin_qual = (mode == GMQ_ASYNC) ? pin_raw : q_r;

	a_hold_level: assert property (@(posedge clock) disable iff (!rst_b)
		((mode == GMQ_WIN3 || mode == GMQ_WIN6) && !win_equal) |=> $stable(q_r))
		else $error("qualified level moved without an equal window");

	a_win_three: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == GMQ_WIN3 && samp_r[2:0] == 3'h7) |=> q_r)
		else $error("three equal high samples did not raise the level");

	a_win_six: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == GMQ_WIN6 && !q_r && samp_r[2:0] == 3'h7 && samp_r[5:3] != 3'h7)
		|=> !q_r)
		else $error("six-sample window changed on three samples");

	a_window_sync: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == GMQ_WIN6 && samp_r == 6'h00) |=> !q_r)
		else $error("six low samples did not clear the level");

endmodule // gmq_qual

// >>> src/gmq_top.sv
/*
 * Port C pin multiplexer with per-pin input qualification. Pins 64-79 go
 * to plain I/O or the external data bus, pins 80-87 to plain I/O or the
 * upper external address bits. All outputs are registered.
 * Assumes a register master on the same clock and pads outside that turn
 * pin_out and pin_oe_b into a wire level.
 */
`timescale 1ns/100ps
`include "gmq_defs.svh"

module gmq_top
	import gmq_pkg::*;
#(
	parameter logic [`GMQ_NDATA-1:0] DATA_IN_DEFAULT   = 16'h0000,
	parameter logic                  SHARED_IN_DEFAULT = 1'b1
)(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// Register port
	input  wire logic [`GMQ_AW-1:0]    reg_addr,
	input  wire logic [`GMQ_DW-1:0]    reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [`GMQ_DW-1:0]    reg_rdata,
	// Package pins 64 to 87, index 0 is pin 64
	input  wire logic [`GMQ_NPIN-1:0]  pin_in,
	output logic      [`GMQ_NPIN-1:0]  pin_out,
	output logic      [`GMQ_NPIN-1:0]  pin_oe_b,
	// External memory interface side
	input  wire logic [`GMQ_NDATA-1:0] ext_data_out,
	input  wire logic                  ext_data_oe,
	output logic      [`GMQ_NDATA-1:0] ext_data_in,
	input  wire logic [`GMQ_NADDR-1:0] ext_addr_hi,
	// Shared peripheral input
	output logic                       periph_shared_in
);

	localparam int NPIN = `GMQ_NPIN;
	localparam int NSEL = `GMQ_NPIN * `GMQ_SEL_W;

	// Software-visible registers.
	logic [`GMQ_DW-1:0]    portc_low_select_r;
	logic [`GMQ_DW-1:0]    portc_low_select_nxt;
	logic [`GMQ_NLOW-1:0]  portc_high_select_r;
	logic [`GMQ_NLOW-1:0]  portc_high_select_nxt;
	logic [`GMQ_DW-1:0]    qsel_low_r;
	logic [`GMQ_DW-1:0]    qsel_low_nxt;
	logic [`GMQ_NLOW-1:0]  qsel_high_r;
	logic [`GMQ_NLOW-1:0]  qsel_high_nxt;
	logic [NPIN-1:0]       port_control_reg_r;
	logic [NPIN-1:0]       port_control_reg_nxt;
	logic [NPIN-1:0]       dir_r;
	logic [NPIN-1:0]       dir_nxt;
	logic [NPIN-1:0]       dout_r;
	logic [NPIN-1:0]       dout_nxt;
	logic [`GMQ_DW-1:0]    rdata_r;
	logic [`GMQ_DW-1:0]    rdata_nxt;

	// Routing outputs.
	logic [NPIN-1:0]       pin_out_r;
	logic [NPIN-1:0]       pin_out_nxt;
	logic [NPIN-1:0]       pin_oe_b_r;
	logic [NPIN-1:0]       pin_oe_b_nxt;
	logic [NPIN-1:0]       din_r;
	logic [NPIN-1:0]       din_nxt;
	logic [`GMQ_NDATA-1:0] ext_in_r;
	logic [`GMQ_NDATA-1:0] ext_in_nxt;
	logic                  shared_r;
	logic                  shared_nxt;

	// Sample period counters, one per eight-pin group.
	logic [`GMQ_PRD_W-1:0] cnt_r   [`GMQ_NGRP];
	logic [`GMQ_PRD_W-1:0] cnt_nxt [`GMQ_NGRP];
	logic [`GMQ_NGRP-1:0]  tick;

	logic [NSEL-1:0]       mux_all;
	logic [NSEL-1:0]       qsel_all;
	logic [NPIN-1:0]       pin_sync;
	logic [NPIN-1:0]       pin_qual;

	assign mux_all  = {portc_high_select_r, portc_low_select_r};
	assign qsel_all = {qsel_high_r, qsel_low_r};

	// Register write and read.
	always_comb begin
		portc_low_select_nxt  = portc_low_select_r;
		portc_high_select_nxt = portc_high_select_r;
		qsel_low_nxt          = qsel_low_r;
		qsel_high_nxt         = qsel_high_r;
		port_control_reg_nxt  = port_control_reg_r;
		dir_nxt               = dir_r;
		dout_nxt              = dout_r;
		if (reg_wr) begin
			unique case (reg_addr)
				`GMQ_OFS_MUX_LO:  portc_low_select_nxt  = reg_wdata;
				`GMQ_OFS_MUX_HI:  portc_high_select_nxt = reg_wdata[`GMQ_NLOW-1:0];
				`GMQ_OFS_QSEL_LO: qsel_low_nxt          = reg_wdata;
				`GMQ_OFS_QSEL_HI: qsel_high_nxt         = reg_wdata[`GMQ_NLOW-1:0];
				`GMQ_OFS_CTRL:    port_control_reg_nxt  = reg_wdata[NPIN-1:0];
				`GMQ_OFS_DIR:     dir_nxt               = reg_wdata[NPIN-1:0];
				`GMQ_OFS_DOUT:    dout_nxt              = reg_wdata[NPIN-1:0];
				default: begin
				end
			endcase
		end
		rdata_nxt = `GMQ_RST_WORD;
		if (reg_rd) begin
			unique case (reg_addr)
				`GMQ_OFS_MUX_LO:  rdata_nxt = portc_low_select_r;
				`GMQ_OFS_MUX_HI:  rdata_nxt = {`GMQ_RST_HALF, portc_high_select_r};
				`GMQ_OFS_QSEL_LO: rdata_nxt = qsel_low_r;
				`GMQ_OFS_QSEL_HI: rdata_nxt = {`GMQ_RST_HALF, qsel_high_r};
				`GMQ_OFS_CTRL:    rdata_nxt = {`GMQ_RST_PRD, port_control_reg_r};
				`GMQ_OFS_DIR:     rdata_nxt = {`GMQ_RST_PRD, dir_r};
				`GMQ_OFS_DOUT:    rdata_nxt = {`GMQ_RST_PRD, dout_r};
				`GMQ_OFS_DIN:     rdata_nxt = {`GMQ_RST_PRD, din_r};
				default:          rdata_nxt = `GMQ_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			portc_low_select_r  <= `GMQ_RST_WORD;
			portc_high_select_r <= `GMQ_RST_HALF;
			qsel_low_r          <= `GMQ_RST_WORD;
			qsel_high_r         <= `GMQ_RST_HALF;
			port_control_reg_r  <= `GMQ_RST_PINS;
			dir_r               <= `GMQ_RST_PINS;
			dout_r              <= `GMQ_RST_PINS;
			rdata_r             <= `GMQ_RST_WORD;
		end else begin
			portc_low_select_r  <= portc_low_select_nxt;
			portc_high_select_r <= portc_high_select_nxt;
			qsel_low_r          <= qsel_low_nxt;
			qsel_high_r         <= qsel_high_nxt;
			port_control_reg_r  <= port_control_reg_nxt;
			dir_r               <= dir_nxt;
			dout_r              <= dout_nxt;
			rdata_r             <= rdata_nxt;
		end
	end

	// A period of zero samples every cycle, otherwise every period cycles.
	always_comb begin
		for (int g = 0; g < `GMQ_NGRP; g++) begin
			logic [`GMQ_PRD_W-1:0] prd;
			prd = port_control_reg_r[g*`GMQ_PRD_W +: `GMQ_PRD_W];
			tick[g] = (prd == `GMQ_RST_PRD) || (cnt_r[g] >= prd - `GMQ_PRD_ONE);
			cnt_nxt[g] = tick[g] ? `GMQ_RST_PRD : cnt_r[g] + `GMQ_PRD_ONE;
		end
	end

	always_ff @(posedge clock) begin
		for (int g = 0; g < `GMQ_NGRP; g++) begin
			if (!rst_b) begin
				cnt_r[g] <= `GMQ_RST_PRD;
			end else begin
				cnt_r[g] <= cnt_nxt[g];
			end
		end
	end

	// Per-pin synchroniser and qualifier.
	for (genvar i = 0; i < NPIN; i++) begin : g_pin
		gmq_sync u_sync (
			.clock    (clock),
			.rst_b    (rst_b),
			.pin_raw  (pin_in[i]),
			.pin_sync (pin_sync[i])
		);

		gmq_qual u_qual (
			.clock       (clock),
			.rst_b       (rst_b),
			.mode        (gmq_qmode_t'(qsel_all[i*`GMQ_SEL_W +: `GMQ_SEL_W])),
			.sample_tick (tick[i / `GMQ_GRP]),
			.pin_sync    (pin_sync[i]),
			.pin_raw     (pin_in[i]),
			.pin_qual    (pin_qual[i])
		);
	end

	// Pin routing. The shared input takes the lowest-numbered pin whose
	// selector is 01, so overlapping selections resolve predictably.
	always_comb begin
		logic found;
		found       = 1'b0;
		shared_nxt  = SHARED_IN_DEFAULT;
		ext_in_nxt  = DATA_IN_DEFAULT;
		pin_out_nxt = dout_r;
		pin_oe_b_nxt = ~dir_r;
		din_nxt     = pin_qual;
		for (int i = 0; i < NPIN; i++) begin
			if (mux_all[i*`GMQ_SEL_W + `GMQ_SEL_BUS]) begin
				if (i < `GMQ_NDATA) begin
					pin_out_nxt[i]  = ext_data_out[`GMQ_NDATA-1-i];
					pin_oe_b_nxt[i] = ~ext_data_oe;
					ext_in_nxt[`GMQ_NDATA-1-i] = pin_qual[i];
				end else begin
					pin_out_nxt[i]  = ext_addr_hi[i-`GMQ_NDATA];
					pin_oe_b_nxt[i] = 1'b0;
				end
			end else if (!found &&
				mux_all[i*`GMQ_SEL_W +: `GMQ_SEL_W] == `GMQ_SEL_PER1) begin
				shared_nxt = pin_qual[i];
				found      = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_out_r  <= `GMQ_RST_PINS;
			pin_oe_b_r <= ~`GMQ_RST_PINS;
			din_r      <= `GMQ_RST_PINS;
			ext_in_r   <= DATA_IN_DEFAULT;
			shared_r   <= SHARED_IN_DEFAULT;
		end else begin
			pin_out_r  <= pin_out_nxt;
			pin_oe_b_r <= pin_oe_b_nxt;
			din_r      <= din_nxt;
			ext_in_r   <= ext_in_nxt;
			shared_r   <= shared_nxt;
		end
	end

	assign reg_rdata        = rdata_r;
	assign pin_out          = pin_out_r;
	assign pin_oe_b         = pin_oe_b_r;
	assign ext_data_in      = ext_in_r;
	assign periph_shared_in = shared_r;

	a_gpio_route: assert property (@(posedge clock) disable iff (!rst_b)
		(!portc_low_select_r[1]) |=>
		(pin_out_r[0] == $past(dout_r[0]) && pin_oe_b_r[0] == !$past(dir_r[0])))
		else $error("pin 64 in plain mode did not follow the port registers");

	a_data_route: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_low_select_r[31] && ext_data_oe) |=>
		(!pin_oe_b_r[15] && pin_out_r[15] == $past(ext_data_out[0])))
		else $error("pin 79 did not carry data bit 0");

	a_addr_route: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_high_select_r[1]) |=>
		(!pin_oe_b_r[16] && pin_out_r[16] == $past(ext_addr_hi[0])))
		else $error("pin 80 did not drive address bit 8");

	a_qsel_reset: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(rst_b) |-> (qsel_low_r == `GMQ_RST_WORD && qsel_high_r == `GMQ_RST_HALF))
		else $error("qualifier selectors not cleared by reset");

	a_sample_space: assert property (@(posedge clock) disable iff (!rst_b)
		(tick[0] && port_control_reg_r[7:0] == 8'h04) |=> (!tick[0] [*3] ##1 tick[0]))
		else $error("group 0 samples not four cycles apart");

	a_async_pass: assert property (@(posedge clock) disable iff (!rst_b)
		(qsel_low_r[1:0] == `GMQ_SEL_ASYNC) |=> (din_r[0] == $past(pin_in[0])))
		else $error("raw mode did not pass pin 64 straight through");

	a_shared_default: assert property (@(posedge clock) disable iff (!rst_b)
		(!found_any()) |=> (periph_shared_in == SHARED_IN_DEFAULT))
		else $error("unrouted shared input left its default level");

	a_shared_pick: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_high_select_r[15:14] == `GMQ_SEL_PER1 && !found_any_below()) |=>
		(periph_shared_in == $past(pin_qual[23])))
		else $error("pin 87 did not reach the shared input");

	// The readback and data-in paths are what software and the bus see.
	a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_b)
		(!reg_rd) |=> (reg_rdata == `GMQ_RST_WORD))
		else $error("read data not cleared outside a read");

	a_rdata_din: assert property (@(posedge clock) disable iff (!rst_b)
		(reg_rd && reg_addr == `GMQ_OFS_DIN) |=> (reg_rdata == {`GMQ_RST_PRD, $past(din_r)}))
		else $error("pin data readback wrong");

	a_oe_reset: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(rst_b) |-> (pin_oe_b_r == ~`GMQ_RST_PINS))
		else $error("pins driven after reset");

	a_plain_per: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_low_select_r[1:0] == `GMQ_SEL_PER1) |=> (pin_out_r[0] == $past(dout_r[0])))
		else $error("pin 64 with selector 01 left plain output");

	a_data_release: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_low_select_r[31] && !ext_data_oe) |=> pin_oe_b_r[15])
		else $error("pin 79 driven while the data bus is idle");

	a_data_in: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_low_select_r[1]) |=> (ext_data_in[15] == $past(pin_qual[0])))
		else $error("pin 64 did not reach data bit 15");

	a_data_unrouted: assert property (@(posedge clock) disable iff (!rst_b)
		(!portc_low_select_r[1]) |=> (ext_data_in[15] == DATA_IN_DEFAULT[15]))
		else $error("unrouted data bit 15 left its default");

	a_addr_top: assert property (@(posedge clock) disable iff (!rst_b)
		(portc_high_select_r[15]) |=>
		(!pin_oe_b_r[23] && pin_out_r[23] == $past(ext_addr_hi[7])))
		else $error("pin 87 did not drive address bit 15");

	a_tick_zero: assert property (@(posedge clock) disable iff (!rst_b)
		(port_control_reg_r[15:8] == `GMQ_RST_PRD) |-> tick[1])
		else $error("group 1 period zero did not sample every cycle");

	a_shared_low: assert property (@(posedge clock) disable iff (!rst_b)
		(mux_all[1:0] == `GMQ_SEL_PER1) |=> (periph_shared_in == $past(pin_qual[0])))
		else $error("pin 64 did not win the shared input");

	function automatic logic found_any();
		logic f;
		f = 1'b0;
		for (int k = 0; k < NPIN; k++) begin
			f = f | (mux_all[k*`GMQ_SEL_W +: `GMQ_SEL_W] == `GMQ_SEL_PER1);
		end
		return f;
	endfunction

	function automatic logic found_any_below();
		logic f;
		f = 1'b0;
		for (int k = 0; k < NPIN-1; k++) begin
			f = f | (mux_all[k*`GMQ_SEL_W +: `GMQ_SEL_W] == `GMQ_SEL_PER1);
		end
		return f;
	endfunction

endmodule // gmq_top

// >>> bench/gmq_pad_model.sv
/*
 * Pad and far-side model for the port C pins: resolves each pin from the
 * block's drive and the outside driver.
 * Assumes the testbench sets far_en and far_lvl after rising clock edges.
 */
`timescale 1ns/100ps

module gmq_pad_model (
	// Clock
	input  wire logic        clock,
	// Block side
	input  wire logic [23:0] pin_out,
	input  wire logic [23:0] pin_oe_b,
	// Outside driver
	input  wire logic [23:0] far_en,
	input  wire logic [23:0] far_lvl,
	// Level seen by the block
	output logic      [23:0] pin_in
);
	// A pin nobody drives has no pull, so it toggles rather than keeping a stale level.
	logic [23:0] float_r = 24'h00_0000;

	always_ff @(posedge clock) begin
		float_r <= ~pin_in;
	end

	always_comb begin
		for (int i = 0; i < 24; i++) begin
			pin_in[i] = !pin_oe_b[i] ? pin_out[i] : (far_en[i] ? far_lvl[i] : float_r[i]);
		end
	end
endmodule // gmq_pad_model

// >>> bench/tb.sv
/*
 * Self-checking testbench for the port C pin multiplexer and qualifier.
 * Assumes the design files and the pad model are compiled before it.
 */
`timescale 1ns/100ps
`include "gmq_defs.svh"

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
	$display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module tb;
	import gmq_pkg::*;
	localparam logic [15:0] DIN_DEF = 16'h5a3c;
	localparam logic        SH_DEF  = 1'b1;
	logic        clock, rst_b, reg_wr, reg_rd, ext_data_oe, periph_shared_in;
	logic [7:0]  reg_addr, ext_addr_hi;
	logic [31:0] reg_wdata, reg_rdata;
	logic [23:0] pin_in, pin_out, pin_oe_b, far_en, far_lvl;
	logic [15:0] ext_data_out, ext_data_in;
	int          err_total, check_count;

	gmq_top #(.DATA_IN_DEFAULT(DIN_DEF), .SHARED_IN_DEFAULT(SH_DEF)) DUT (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_data_out(ext_data_out),
		.ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .ext_addr_hi(ext_addr_hi),
		.periph_shared_in(periph_shared_in));

	gmq_pad_model pads (.clock(clock), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
		.far_en(far_en), .far_lvl(far_lvl), .pin_in(pin_in));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK("read data", ex, reg_rdata)
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic t_reset();
		`CHK("oe after reset", 24'hff_ffff, pin_oe_b)
		`CHK("out after reset", 24'h00_0000, pin_out)
		`CHK("bus data default", DIN_DEF, ext_data_in)
		`CHK("shared default", SH_DEF, periph_shared_in)
		rd(`GMQ_OFS_QSEL_LO, 32'h0000_0000);
		rd(`GMQ_OFS_QSEL_HI, 32'h0000_0000);
		rd(`GMQ_OFS_CTRL, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_route();
		ext_data_oe  <= 1'b1;
		ext_data_out <= 16'h1234;
		ext_addr_hi  <= 8'h5c;
		for (int c = 2; c < 4; c++) begin
			wr(`GMQ_OFS_MUX_LO, {16{c[1:0]}});
			wr(`GMQ_OFS_MUX_HI, {16'h0000, {8{c[1:0]}}});
			wait_cyc(3);
			`CHK("data bus out", 16'h2c48, pin_out[15:0])
			`CHK("data bus oe", 16'h0000, pin_oe_b[15:0])
			`CHK("addr out", 8'h5c, pin_out[23:16])
			`CHK("addr oe", 8'h00, pin_oe_b[23:16])
		end
		ext_data_oe <= 1'b0;
		far_lvl     <= 24'h00_c3a5;
		wait_cyc(10);
		`CHK("data bus released", 16'hffff, pin_oe_b[15:0])
		`CHK("data bus in", 16'ha5c3, ext_data_in)
		wr(`GMQ_OFS_DIR, 32'h00ff_ffff);
		wr(`GMQ_OFS_DOUT, 32'h0096_3c5a);
		for (int c = 0; c < 2; c++) begin
			wr(`GMQ_OFS_MUX_LO, {16{c[1:0]}});
			wr(`GMQ_OFS_MUX_HI, {16'h0000, {8{c[1:0]}}});
			wait_cyc(3);
			`CHK("plain out", 24'h96_3c5a, pin_out)
			`CHK("plain oe", 24'h00_0000, pin_oe_b)
		end
		wr(`GMQ_OFS_DIR, 32'h0000_0000);
		$display("test route done");
	endtask

	task automatic t_shared();
		wr(`GMQ_OFS_MUX_LO, 32'h0000_0000);
		wr(`GMQ_OFS_MUX_HI, 32'h0000_0000);
		far_lvl <= 24'h02_0000;
		wr(`GMQ_OFS_MUX_LO, 32'h0000_0040);
		wr(`GMQ_OFS_MUX_HI, 32'h0000_0004);
		wait_cyc(8);
		`CHK("shared from pin 3", 1'b0, periph_shared_in)
		wr(`GMQ_OFS_MUX_LO, 32'h0000_0000);
		wait_cyc(8);
		`CHK("shared from pin 17", 1'b1, periph_shared_in)
		far_lvl <= 24'h00_0000;
		wait_cyc(8);
		`CHK("shared follows pin 17", 1'b0, periph_shared_in)
		wr(`GMQ_OFS_MUX_HI, 32'h0000_0000);
		wait_cyc(3);
		`CHK("shared unrouted", SH_DEF, periph_shared_in)
		$display("test shared done");
	endtask

	task automatic t_qual();
		wr(`GMQ_OFS_MUX_LO, 32'haaaa_aaaa);
		wr(`GMQ_OFS_CTRL, 32'h0004_0008);
		wr(`GMQ_OFS_QSEL_LO, 32'h0001_0009);
		wait_cyc(20);
		far_lvl <= 24'h00_0103;
		wait_cyc(10);
		`CHK("short glitch", 16'h0080, ext_data_in)
		far_lvl <= 24'h00_0000;
		wait_cyc(60);
		far_lvl <= 24'h00_0103;
		wait_cyc(100);
		`CHK("held level", 16'hc080, ext_data_in)
		far_lvl <= 24'h00_0000;
		wait_cyc(100);
		`CHK("back low", 16'h0000, ext_data_in)
		wr(`GMQ_OFS_QSEL_LO, 32'h0001_0039);
		rd(`GMQ_OFS_QSEL_LO, 32'h0001_0039);
		@(posedge clock);
		far_lvl <= 24'h00_0014;
		wait_cyc(2);
		`CHK("raw pin", 1'b1, ext_data_in[13])
		`CHK("sync pin early", 1'b0, ext_data_in[11])
		wait_cyc(8);
		`CHK("sync pin late", 1'b1, ext_data_in[11])
		$display("test qual done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clock);
		err_total++;
		results();
	end

	initial begin
		err_total    = 0;
		check_count  = 0;
		rst_b        = 1'b0;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		reg_addr     = 8'h00;
		reg_wdata    = 32'h0000_0000;
		ext_data_out = 16'h0000;
		ext_data_oe  = 1'b0;
		ext_addr_hi  = 8'h00;
		far_en       = 24'hff_ffff;
		far_lvl      = 24'h00_0000;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		wait_cyc(1);
		t_reset();
		t_route();
		t_shared();
		t_qual();
		results();
	end
endmodule // tb
